// >>> design/stc_pkg.sv
// stc_pkg: constants, register map and field layouts of the split timer/counter
// assumes: a 32-bit APB slave sits in front of the registers, clock at 100 MHz
package stc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_CFG    = 8'h00; // mode, edges, clock source
  localparam logic [7:0] ADDR_CTRL   = 8'h04; // run, gate, outputs, polarity
  localparam logic [7:0] ADDR_STAT   = 8'h08; // sticky flags, write 1 to clear
  localparam logic [7:0] ADDR_VALUE  = 8'h0C; // count_value (upper/lower count)
  localparam logic [7:0] ADDR_RELOAD = 8'h10; // reload_value (upper/lower reload)
  localparam logic [7:0] ADDR_CMP    = 8'h14; // compare_value (upper/lower compare)

  // flag positions in the status register
  localparam int FLG_OVF  = 0; // overflow_flag
  localparam int FLG_CMP  = 1; // compare_flag
  localparam int FLG_LOVF = 2; // low_overflow_flag
  localparam int FLG_LCMP = 3; // low_compare_flag
  localparam int FLG_W    = 4;

  // edge_select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // counting limits
  localparam logic [15:0] MAX16 = 16'hFFFF; // full 16-bit range
  localparam logic [15:0] MAX8  = 16'h00FF; // one 8-bit half

  // clock source figures
  localparam int SYS_CLK_KHZ = 100000; // system clock rate
  localparam int ALT_CLK_KHZ = 32;     // alternate clock nominal rate
  localparam int ALT_MIN_DIV = 4;      // alternate no faster than sys/4

  // configuration register layout, msb first
  typedef struct packed {
    logic       clock_source_select; // 7: 1 = sampled alternate clock
    logic [2:0] prescale_field;      // 6:4 divide by 2**n
    logic       split_mode;          // 3: dual 8-bit timers
    logic [1:0] edge_select;         // 2:1 counted / captured edges
    logic       count_select;        // 0: count pin edges
  } stc_cfg_s;

  // control register layout, msb first
  typedef struct packed {
    logic out_en_secondary; // 8
    logic pol_secondary;    // 7
    logic irq_enable;       // 6
    logic out_en_primary;   // 5
    logic pol_primary;      // 4
    logic run_secondary;    // 3
    logic run_primary;      // 2
    logic one_shot;         // 1: cleared by hardware on reload
    logic gate_enable;      // 0
  } stc_ctrl_s;

  localparam stc_cfg_s  CFG_RST  = '0;
  localparam stc_ctrl_s CTRL_RST = '0;
  localparam int CFG_W  = $bits(stc_cfg_s);
  localparam int CTRL_W = $bits(stc_ctrl_s);

endpackage : stc_pkg

// >>> design/stc_clk_src.sv
// stc_clk_src: timer input clock selection and prescaler, one tick per timer clock
// assumes: alt_clk_in is a slow free-running level, at most a quarter of clk
`timescale 1ns/100ps

module stc_clk_src #(
  parameter int DIV_W = 3 // width of the prescale field
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // selection
  input  wire logic             src_sel,  // 1 = alternate clock
  input  wire logic [DIV_W-1:0] div_sel,  // divide by 2**div_sel
  input  wire logic             alt_clk_in,
  // result
  output logic                  tick
);

  localparam int CNT_W = (1 << DIV_W) - 1; // widest divider needed

  initial
  begin
    if (DIV_W < 1 || DIV_W > 4)
      $error("stc_clk_src: DIV_W out of range");
    if (stc_pkg::SYS_CLK_KHZ < stc_pkg::ALT_MIN_DIV * stc_pkg::ALT_CLK_KHZ)
      $error("stc_clk_src: alternate clock too fast to sample");
  end

  logic             alt_s1;   // first sync stage, read only by alt_s2
  logic             alt_s2;   // second sync stage
  logic             alt_s3;   // edge history
  logic [CNT_W-1:0] pre_cnt;  // prescaler count
  logic             base;     // undivided timer clock enable
  logic [CNT_W-1:0] mask;     // low bits that must all be set
  logic [CNT_W-1:0] next_cnt;
  logic             next_tick;

  // source pick and divide; sampling limits alternate to sys/4
  always_comb
  begin
    base      = src_sel ? (alt_s2 & ~alt_s3) : 1'b1;
    mask      = CNT_W'((1 << div_sel) - 1);
    next_cnt  = pre_cnt;
    next_tick = 1'b0;
    if (base)
    begin
      next_cnt  = CNT_W'(pre_cnt + 1'b1);
      next_tick = ((pre_cnt & mask) == mask);
    end
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      alt_s1  <= 1'b0;
      alt_s2  <= 1'b0;
      alt_s3  <= 1'b0;
      pre_cnt <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      alt_s1  <= alt_clk_in;
      alt_s2  <= alt_s1;
      alt_s3  <= alt_s2;
      pre_cnt <= next_cnt;
      tick    <= next_tick;
    end
  end

endmodule : stc_clk_src

// >>> design/stc_timer.sv
// stc_timer: counter, dual 8-bit timer, 8-bit capture and 8-bit counter modes
// assumes: APB master on the bus side, pins synchronous to clk, one clock domain
//
// Contract
// - count_select counts chosen pin edges in value
// - edge codes rise, fall, both
// - edge_select zero holds the count
// - overflow loads reload, not zero
// - overflow sets flag, interrupt when enabled
// - compare match sets flag, interrupt when enabled
// - compare outside reload..max never matches
// - counter: primary pin input, secondary toggles
// - polarity takes effect on enable rising
// - split mode halves value, reload, compare
// - secondary has own run, flags
// - both timer outputs go to internals
// - enables route halves to their pins
// - output starts at polarity, toggles on events
// - primary gated when pin equals polarity, primary output off
// - secondary never gated
// - single-shot runs primary until reload
// - single-shot with run keeps output running
// - nonzero edges capture primary only
// - split counter reloads upper half, flags
// - clock source select, alternate sampled, prescaled
`timescale 1ns/100ps

module stc_timer #(
  parameter int DIV_W = 3 // prescale field width
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        alt_clk_in,       // slow alternate clock
  input  wire logic        primary_pin_in,
  output logic             primary_pin_out,
  output logic             primary_pin_oe,
  output logic             secondary_pin_out,
  output logic             secondary_pin_oe,
  // internal peripherals
  output logic             primary_clk_out,  // raw primary timer output
  output logic             secondary_clk_out, // raw secondary timer output
  output logic             irq_req
);

  // only a three-bit prescale field is decoded below
  initial
  begin
    if (DIV_W != 3)
      $error("stc_timer: prescale field is three bits wide");
  end

  // step result: {overflow, match, next value}
  typedef logic [17:0] stc_step_t;

  // one count step within [r..m]; match only when c inside that range
  function automatic stc_step_t stc_step(input logic [15:0] v, input logic [15:0] r,
                                         input logic [15:0] c, input logic [15:0] m,
                                         input logic en);
    logic [15:0] nv;
    logic        ov;
    // a step without enable keeps the value and flags nothing
    nv = v;
    ov = 1'b0;
    if (en)
    begin
      ov = (v == m);
      nv = ov ? r : 16'(v + 16'h0001);
    end
    return {ov, en & (nv == c) & (c >= r) & (c <= m), nv};
  endfunction : stc_step

  // edge decode of the sampled primary pin
  function automatic logic stc_edge(input logic [1:0] sel, input logic cur, input logic prv);
    case (sel)
      stc_pkg::EDGE_RISE: return cur & ~prv;
      stc_pkg::EDGE_FALL: return ~cur & prv;
      stc_pkg::EDGE_BOTH: return cur ^ prv;
      default:            return 1'b0; // none counted
    endcase
  endfunction : stc_edge

  // register state
  stc_pkg::stc_cfg_s   cfg;          // configuration
  stc_pkg::stc_ctrl_s  ctrl;         // control bits
  logic [stc_pkg::FLG_W-1:0] flags;  // sticky flags

  logic [15:0] count_value;          // upper_count : lower_count
  logic [15:0] reload_value;         // upper_reload : lower_reload
  logic [15:0] compare_value;        // upper_compare : lower_compare

  logic        pin_prev;             // primary pin history
  logic        oe_p_prev;            // enable history for polarity latch
  logic        oe_s_prev;

  logic        tog_p;                // raw primary timer output
  logic        tog_s;                // raw secondary timer output
  logic        lev_p;                // primary pin level
  logic        lev_s;                // secondary pin level

  // next values
  stc_pkg::stc_cfg_s   next_cfg;
  stc_pkg::stc_ctrl_s  next_ctrl;
  logic [stc_pkg::FLG_W-1:0] next_flags;

  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic [15:0] next_compare;

  logic        next_tog_p;
  logic        next_tog_s;
  logic        next_lev_p;
  logic        next_lev_s;

  logic        next_irq;
  logic [31:0] next_prdata;

  // working terms
  logic        tick;        // prescaled timer clock enable
  logic        wr;          // write strobe in access phase
  logic        hit;         // address is mapped

  logic        edge_hit;    // selected pin edge seen
  logic        gated;       // primary clock blocked by pin
  logic        capturing;   // primary in capture mode

  logic        inc_p;       // primary counts this cycle
  logic        inc_s;       // secondary counts this cycle

  logic        ev_p;        // primary overflow or match
  logic        ev_s;        // secondary overflow or match
  logic        ovf_p;
  logic        ovf_s;
  logic        cap_p;       // capture taken

  // flag set and clear terms
  logic [stc_pkg::FLG_W-1:0] set_f;
  logic [stc_pkg::FLG_W-1:0] clr_f;

  // step results of the full, upper and lower counters
  stc_step_t   r16;
  stc_step_t   rh;
  stc_step_t   rl;

  // timer clock source and prescaler
  stc_clk_src #(
    .DIV_W      (DIV_W)
  ) u_clk_src (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .src_sel    (cfg.clock_source_select),
    .div_sel    (cfg.prescale_field),
    .alt_clk_in (alt_clk_in),
    .tick       (tick)
  );

  // zero wait state slave; unmapped offsets answer with an error
  always_comb
  begin
    hit     = (paddr == stc_pkg::ADDR_CFG) || (paddr == stc_pkg::ADDR_CTRL) ||
              (paddr == stc_pkg::ADDR_STAT) || (paddr == stc_pkg::ADDR_VALUE) ||
              (paddr == stc_pkg::ADDR_RELOAD) || (paddr == stc_pkg::ADDR_CMP);
    pready  = psel & penable;
    pslverr = psel & penable & ~hit;
    wr      = psel & penable & pwrite & hit;
  end

  // read data captured in the setup cycle so the access phase sees a flop
  always_comb
  begin
    next_prdata = prdata;
    if (psel & ~penable)
    begin
      case (paddr)
        stc_pkg::ADDR_CFG:    next_prdata = 32'(cfg);
        stc_pkg::ADDR_CTRL:   next_prdata = 32'(ctrl);
        stc_pkg::ADDR_STAT:   next_prdata = 32'(flags);
        stc_pkg::ADDR_VALUE:  next_prdata = 32'(count_value);
        stc_pkg::ADDR_RELOAD: next_prdata = 32'(reload_value);
        stc_pkg::ADDR_CMP:    next_prdata = 32'(compare_value);
        default:              next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // timer next state; bus writes to value win over counting
  always_comb
  begin
    // primary clock is blocked only while its pin is an input
    gated     = ctrl.gate_enable & ~ctrl.out_en_primary &
                (primary_pin_in == ctrl.pol_primary);
    edge_hit  = stc_edge(cfg.edge_select, primary_pin_in, pin_prev);
    capturing = ~cfg.count_select & (cfg.edge_select != stc_pkg::EDGE_NONE);
    // single-shot overrides a stopped run bit until reload
    inc_p     = cfg.count_select ? edge_hit :
                (tick & (ctrl.run_primary | ctrl.one_shot) & ~gated);
    // secondary: own run bit, never gated, split mode only
    inc_s     = cfg.split_mode & tick & ctrl.run_secondary;
    r16       = stc_step(count_value, reload_value, compare_value, stc_pkg::MAX16, inc_p);
    rh        = stc_step({8'h00, count_value[15:8]}, {8'h00, reload_value[15:8]},
                         {8'h00, compare_value[15:8]}, stc_pkg::MAX8, inc_p);
    rl        = stc_step({8'h00, count_value[7:0]}, {8'h00, reload_value[7:0]},
                         {8'h00, compare_value[7:0]}, stc_pkg::MAX8, inc_s);
    cap_p     = capturing & edge_hit;

    next_count   = count_value;
    next_reload  = reload_value;
    next_compare = compare_value;
    set_f        = '0;
    ovf_s        = 1'b0;
    ev_s         = 1'b0;

    if (cfg.split_mode)
    begin
      // upper half is the primary, lower half the secondary
      next_count = {rh[7:0], rl[7:0]};
      ovf_p      = rh[17];
      ev_p       = rh[17] | (rh[16] & ~capturing);
      ovf_s      = rl[17];
      ev_s       = rl[17] | rl[16];
      set_f[stc_pkg::FLG_LOVF] = rl[17];
      set_f[stc_pkg::FLG_LCMP] = rl[16];
      set_f[stc_pkg::FLG_CMP]  = (rh[16] & ~capturing) | cap_p;
      if (cap_p)
        next_compare[15:8] = count_value[15:8];
    end
    else
    begin
      next_count = r16[15:0];
      ovf_p      = r16[17];
      ev_p       = r16[17] | (r16[16] & ~capturing);
      set_f[stc_pkg::FLG_CMP] = (r16[16] & ~capturing) | cap_p;
      if (cap_p)
        next_compare = count_value;
    end

    set_f[stc_pkg::FLG_OVF] = ovf_p;
    // status clears by writing ones; a same-cycle set wins
    clr_f = (wr && paddr == stc_pkg::ADDR_STAT) ? pwdata[stc_pkg::FLG_W-1:0] : '0;
    next_flags = (flags & ~clr_f) | set_f;

    // software loads come last, so a write beats the step
    if (wr && paddr == stc_pkg::ADDR_VALUE)
      next_count = pwdata[15:0];
    if (wr && paddr == stc_pkg::ADDR_RELOAD)
      next_reload = pwdata[15:0];
    if (wr && paddr == stc_pkg::ADDR_CMP)
      next_compare = pwdata[15:0];
  end

  // configuration, control and output waveform next state
  always_comb
  begin
    next_cfg  = cfg;
    next_ctrl = ctrl;
    if (wr && paddr == stc_pkg::ADDR_CFG)
      next_cfg = stc_pkg::stc_cfg_s'(pwdata[stc_pkg::CFG_W-1:0]);

    // single-shot falls at the primary reload; run bit keeps the output going
    if (ovf_p)
      next_ctrl.one_shot = 1'b0;
    if (wr && paddr == stc_pkg::ADDR_CTRL)
      next_ctrl = stc_pkg::stc_ctrl_s'(pwdata[stc_pkg::CTRL_W-1:0]);

    // raw outputs toggle on overflow or match; 16-bit mode drives both from one timer
    next_tog_p = tog_p ^ ev_p;
    next_tog_s = cfg.split_mode ? (tog_s ^ ev_s) : (tog_s ^ ev_p);

    // pin level restarts at polarity when its enable rises
    next_lev_p = lev_p ^ ev_p;
    // the primary enable as the pin sees it: counter mode keeps it low
    if (primary_pin_oe & ~oe_p_prev)
      next_lev_p = ctrl.pol_primary;
    next_lev_s = cfg.split_mode ? (lev_s ^ ev_s) : (lev_s ^ ev_p);
    if (ctrl.out_en_secondary & ~oe_s_prev)
      next_lev_s = ctrl.pol_secondary;

    // one request line from the enabled flags
    next_irq = ctrl.irq_enable & (|next_flags);
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg           <= stc_pkg::CFG_RST;
      ctrl          <= stc_pkg::CTRL_RST;
      flags         <= '0;
      count_value   <= 16'h0000;
      reload_value  <= 16'h0000;
      compare_value <= 16'h0000;
      pin_prev      <= 1'b0;
      oe_p_prev     <= 1'b0;
      oe_s_prev     <= 1'b0;
      tog_p         <= 1'b0;
      tog_s         <= 1'b0;
      lev_p         <= 1'b0;
      lev_s         <= 1'b0;
      irq_req       <= 1'b0;
      prdata        <= 32'h0000_0000;
    end
    else
    begin
      cfg           <= next_cfg;
      ctrl          <= next_ctrl;
      flags         <= next_flags;
      count_value   <= next_count;
      reload_value  <= next_reload;
      compare_value <= next_compare;
      pin_prev      <= primary_pin_in;
      oe_p_prev     <= primary_pin_oe;
      oe_s_prev     <= ctrl.out_en_secondary;
      tog_p         <= next_tog_p;
      tog_s         <= next_tog_s;
      lev_p         <= next_lev_p;
      lev_s         <= next_lev_s;
      irq_req       <= next_irq;
      prdata        <= next_prdata;
    end
  end

  // pin drive; counter mode keeps the primary pin an input
  always_comb
  begin
    primary_pin_oe    = ctrl.out_en_primary & ~cfg.count_select;
    primary_pin_out   = lev_p;
    secondary_pin_oe  = ctrl.out_en_secondary;
    secondary_pin_out = lev_s;

    primary_clk_out   = tog_p;
    secondary_clk_out = tog_s;
  end

endmodule : stc_timer

// >>> bench/stc_timer_chk.sv
// stc_timer_chk: port-level checks of the split timer/counter
// assumes: bound to stc_timer; cfg and ctrl are snooped from apb writes
`timescale 1ns/100ps

module stc_timer_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // pins and internal outputs
  input wire logic        primary_pin_in,
  input wire logic        primary_pin_out,
  input wire logic        primary_pin_oe,
  input wire logic        secondary_pin_out,
  input wire logic        secondary_pin_oe,
  input wire logic        primary_clk_out,
  input wire logic        irq_req
);
  stc_pkg::stc_cfg_s  cfg, next_cfg;     // snooped config
  stc_pkg::stc_ctrl_s ctl, next_ctl;     // snooped control
  logic [4:0]         pin_h, next_pin_h; // pin samples, newest low
  logic [2:0]         quiet, next_quiet; // cycles since a write, saturating
  logic               wr;                // write lands this edge

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // next values; one_shot self-clear is not tracked, no check needs it
  always_comb
  begin
    wr         = psel && penable && pready && pwrite;
    next_cfg   = cfg;
    next_ctl   = ctl;
    next_pin_h = {pin_h[3:0], primary_pin_in};
    next_quiet = (quiet == 3'h7) ? quiet : quiet + 3'h1;
    if (wr && paddr == stc_pkg::ADDR_CFG)
      next_cfg = pwdata[stc_pkg::CFG_W-1:0];
    if (wr && paddr == stc_pkg::ADDR_CTRL)
      next_ctl = pwdata[stc_pkg::CTRL_W-1:0];
    if (wr)
      next_quiet = 3'h0;
  end

  // registers, cleared like the design
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg   <= stc_pkg::CFG_RST;
      ctl   <= stc_pkg::CTRL_RST;
      pin_h <= 5'h00;
      quiet <= 3'h0;
    end
    else
    begin
      cfg   <= next_cfg;
      ctl   <= next_ctl;
      pin_h <= next_pin_h;
      quiet <= next_quiet;
    end
  end

  AST_OE_CNT: assert property (cfg.count_select && quiet > 3'h1 |-> !primary_pin_oe)
    else $error("primary pin driven while counting");
  AST_OE_PRI: assert property (!cfg.count_select && quiet > 3'h1 |-> primary_pin_oe == ctl.out_en_primary)
    else $error("primary enable mismatch");
  AST_OE_SEC: assert property (quiet > 3'h1 |-> secondary_pin_oe == ctl.out_en_secondary)
    else $error("secondary enable mismatch");
  AST_SEC_START: assert property ($rose(secondary_pin_oe) |=> secondary_pin_out == ctl.pol_secondary)
    else $error("secondary start level wrong");
  AST_PRI_START: assert property ($rose(primary_pin_oe) |=> primary_pin_out == ctl.pol_primary)
    else $error("primary start level wrong");
  AST_IRQ_MASK: assert property (!ctl.irq_enable && !$past(ctl.irq_enable) |-> !irq_req)
    else $error("interrupt while disabled");
  // a toggle in counter mode needs a pin edge in the last few samples
  AST_CNT_EDGE: assert property (cfg.count_select && !cfg.split_mode && quiet == 3'h7
    && $changed(primary_clk_out) |-> |(pin_h ^ {pin_h[3:0], primary_pin_in}))
    else $error("counter event without pin edge");
  AST_CNT_HOLD: assert property (cfg.count_select && cfg.edge_select == stc_pkg::EDGE_NONE
    && quiet == 3'h7 |-> $stable(primary_clk_out))
    else $error("counter moved with no edge chosen");
endmodule : stc_timer_chk

// >>> bench/stc_pin_model.sv
// stc_pin_model: far side of the primary pin, an edge source
// assumes: levels change only just after a rising clk edge
`timescale 1ns/100ps

module stc_pin_model (
  // clock
  input wire logic clk,
  // device side of the pin
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic     pin_in
);
  logic drv = 1'b0; // level the source drives

  // resolved pin: the device wins while it drives
  assign pin_in = pin_oe ? pin_out : drv;

  // n full pulses, eight clocks per level so every level is sampled
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge clk);
      drv <= 1'b1;
      repeat (8) @(posedge clk);
      drv <= 1'b0;
    end
    repeat (3) @(posedge clk); // let the last edge be counted
  endtask : pulses
endmodule : stc_pin_model

// >>> bench/test_split_timer_counter_modes.sv
// test_split_timer_counter_modes: self-checking bench of the split timer/counter
// assumes: stc_timer as uut, pin model on the primary pin, checker bound below
`timescale 1ns/100ps

module test_split_timer_counter_modes;
  logic               clk, sys_rst, psel, penable, pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic               pready, pslverr, pin_in, p_out, p_oe, s_out, s_oe, irq_req, alt_clk, s_clk, sc;
  logic [32:0]        exp_q[$];  // expected {slverr, rdata} per read
  int                 n_errors, total_checks;
  logic [15:0]        lf, r;     // random state and a drawn reload
  stc_pkg::stc_cfg_s  cfg;       // config being built
  stc_pkg::stc_ctrl_s ctl;       // control being built

  stc_timer uut (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .alt_clk_in        (alt_clk),
    .primary_pin_in    (pin_in),
    .primary_pin_out   (p_out),
    .primary_pin_oe    (p_oe),
    .secondary_pin_out (s_out),
    .secondary_pin_oe  (s_oe),
    .primary_clk_out   (),
    .secondary_clk_out (s_clk),
    .irq_req
  );

  stc_pin_model ext (.clk, .pin_out(p_out), .pin_oe(p_oe), .pin_in);

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic cmp_word(input string what, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : cmp_bit

  // one apb transfer; a missing pready ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!pready && k < 20);
    if (!pready)
    begin
      n_errors++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // note the expectation first, the monitor takes it off
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // read monitor: oldest note against each completed read
  always @(posedge clk)
    if (psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
        cmp_word("read note", 33'h0, 33'h1);
      else
        cmp_word("read", exp_q.pop_front(), {pslverr, prdata});
    end

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt_clk = 1'b0;
    n_errors = 0;
    total_checks = 0;
    lf = 16'hC4D1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h18, {1'b1, 32'h0});
    // every edge code, two full pulses each
    for (int e = 0; e < 4; e++)
    begin
      cfg = '0;
      cfg.count_select = 1'b1;
      cfg.edge_select = e[1:0];
      wr(stc_pkg::ADDR_CFG, 32'(cfg));
      wr(stc_pkg::ADDR_VALUE, 32'h0);
      wr(stc_pkg::ADDR_CMP, 32'h8000);
      ext.pulses(2);
      rd(stc_pkg::ADDR_VALUE, 33'((e + 1) / 2 * 2));
    end
    // overflow reloads a random value; compare 0 lies below it
    lf = lfsr(lf);
    r = {1'b0, lf[14:0]} | 16'h0100;
    ctl = '0;
    ctl.irq_enable = 1'b1;
    ctl.out_en_primary = 1'b1;
    ctl.out_en_secondary = 1'b1;
    ctl.pol_secondary = 1'b1;
    wr(stc_pkg::ADDR_CTRL, 32'(ctl)); // gate and single-shot off while counting
    cfg.edge_select = stc_pkg::EDGE_RISE;
    wr(stc_pkg::ADDR_CFG, 32'(cfg));
    wr(stc_pkg::ADDR_CMP, 32'h0);
    wr(stc_pkg::ADDR_RELOAD, 32'(r));
    wr(stc_pkg::ADDR_VALUE, 32'hFFFF);
    wr(stc_pkg::ADDR_STAT, 32'hF);
    @(negedge clk);
    cmp_bit("secondary start", 1'b1, s_out);
    cmp_bit("primary oe", 1'b0, p_oe);
    ext.pulses(1);
    rd(stc_pkg::ADDR_VALUE, 33'(r));
    rd(stc_pkg::ADDR_STAT, 33'h1);
    @(negedge clk);
    cmp_bit("irq", 1'b1, irq_req);
    cmp_bit("secondary toggle", 1'b0, s_out);
    // match one above the reload value
    wr(stc_pkg::ADDR_STAT, 32'hF);
    wr(stc_pkg::ADDR_CMP, 32'(r + 16'h1));
    ext.pulses(1);
    rd(stc_pkg::ADDR_STAT, 33'h2);
    ctl.irq_enable = 1'b0;
    wr(stc_pkg::ADDR_CTRL, 32'(ctl));
    repeat (2) @(negedge clk);
    cmp_bit("secondary toggle", 1'b1, s_out);
    cmp_bit("irq masked", 1'b0, irq_req);
    // split counter: upper half counts and reloads, lower stopped
    cfg = '0;
    cfg.split_mode = 1'b1;
    cfg.count_select = 1'b1;
    cfg.edge_select = stc_pkg::EDGE_RISE;
    wr(stc_pkg::ADDR_CFG, 32'(cfg));
    wr(stc_pkg::ADDR_RELOAD, 32'hAB00);
    wr(stc_pkg::ADDR_VALUE, 32'hFF00);
    wr(stc_pkg::ADDR_CMP, 32'hAC80);
    wr(stc_pkg::ADDR_STAT, 32'hF);
    ext.pulses(2);
    rd(stc_pkg::ADDR_VALUE, 33'hAC00);
    rd(stc_pkg::ADDR_STAT, 33'h3);
    // split timer: lower runs, primary held by its gate
    cfg.count_select = 1'b0;
    cfg.edge_select = stc_pkg::EDGE_NONE;
    wr(stc_pkg::ADDR_CFG, 32'(cfg));
    wr(stc_pkg::ADDR_VALUE, 32'hFEFE);
    wr(stc_pkg::ADDR_RELOAD, 32'h0);
    wr(stc_pkg::ADDR_CMP, 32'hAD05);
    wr(stc_pkg::ADDR_STAT, 32'hF);
    ctl = '0;
    ctl.run_secondary = 1'b1;
    ctl.run_primary = 1'b1;
    ctl.gate_enable = 1'b1;
    wr(stc_pkg::ADDR_CTRL, 32'(ctl));
    @(negedge clk);
    sc = s_clk;
    repeat (3) @(negedge clk);
    cmp_bit("secondary clk", ~sc, s_clk);
    repeat (20) @(posedge clk);
    rd(stc_pkg::ADDR_STAT, 33'hC);
    // single-shot on the primary half only
    wr(stc_pkg::ADDR_CTRL, 32'h0);
    wr(stc_pkg::ADDR_VALUE, 32'hFE00);
    wr(stc_pkg::ADDR_RELOAD, 32'h1000);
    wr(stc_pkg::ADDR_STAT, 32'hF);
    ctl = '0;
    ctl.one_shot = 1'b1;
    ctl.out_en_primary = 1'b1;
    ctl.pol_primary = 1'b1;
    wr(stc_pkg::ADDR_CTRL, 32'(ctl));
    repeat (20) @(posedge clk);
    rd(stc_pkg::ADDR_VALUE, 33'h1000);
    rd(stc_pkg::ADDR_CTRL, 33'(ctl) & ~33'h2);
    rd(stc_pkg::ADDR_STAT, 33'h1);
    @(negedge clk);
    cmp_bit("primary toggle", 1'b0, p_out);
    // alternate source halved: eight rising edges give four counts
    cfg = '0;
    cfg.clock_source_select = 1'b1;
    cfg.prescale_field = 3'h1;
    wr(stc_pkg::ADDR_CFG, 32'(cfg));
    ctl = '0;
    ctl.run_primary = 1'b1;
    wr(stc_pkg::ADDR_CTRL, 32'(ctl));
    wr(stc_pkg::ADDR_VALUE, 32'h0);
    repeat (16)
    begin
      repeat (4) @(posedge clk);
      alt_clk <= ~alt_clk;
    end
    repeat (8) @(posedge clk);
    rd(stc_pkg::ADDR_VALUE, 33'h4);
    finish_test();
  end
endmodule : test_split_timer_counter_modes

bind stc_timer stc_timer_chk chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .primary_pin_in, .primary_pin_out, .primary_pin_oe, .secondary_pin_out, .secondary_pin_oe,
  .primary_clk_out, .irq_req);
